// >>> rtl/nrw_noise_word_source.sv
// AHB-lite slave random word source with ready flag and stalling value read
//
// Overview of operation
// R01 - Value read gives word in 15:0, zero above
// R02 - Non-32-bit access answered with error response
// R03 - Fresh words no faster than 1.25 us
// R04 - Off bit stops oscillators and gates clock
// R05 - Value read waits until word available
// R06 - Ready flag set when word valid
// R07 - Ready flag held low while generator off
// R08 - Software writes reserved bits as zero
// R09 - Registers at 0x00/0x04/0x08, reset to zero
// R10 - Reading a valid word clears ready flag
`timescale 1ns/1ps
`include "nrw_cfg.svh"

module nrw_noise_word_source
	import nrw_pkg::*;
(
	input  wire logic        core_clk,
	input  wire logic        sys_rst,
	input  wire logic        hsel,
	input  wire logic [7:0]  haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	input  wire logic        noise_bit,
	output logic             osc_power_down,
	output logic             gen_clk_gate_off
);
	localparam int unsigned WORD_CYCLES = `NRW_WORD_CYCLES;
	localparam logic [6:0]  TICK_LAST   = 7'(WORD_CYCLES - 1);
	localparam logic [4:0]  WORD_BITS   = 5'd16;

	// Noise pin comes from an analog domain
	logic        noise_s1_ff;
	logic        noise_s2_ff;

	// Generator state
	logic        gen_off_ff;
	logic        nxt_gen_off;
	logic [15:0] shift_ff;
	logic [15:0] nxt_shift;
	logic [15:0] value_ff;
	logic [15:0] nxt_value;
	logic        ready_ff;
	logic        nxt_ready;
	logic [6:0]  tick_ff;
	logic [6:0]  nxt_tick;
	logic [4:0]  bits_ff;
	logic [4:0]  nxt_bits;

	// Bus state
	nrw_bus_type bus_ff;
	nrw_bus_type nxt_bus;
	logic        wr_pend_ff;
	logic        nxt_wr_pend;
	logic        rd_pend_ff;
	logic        nxt_rd_pend;
	logic [7:0]  addr_ff;
	logic [7:0]  nxt_addr;
	logic [31:0] rdata_ff;
	logic [31:0] nxt_rdata;

	// Glue between the two groups
	logic        req;
	logic        bad_size;
	logic        ctl_write;
	logic        off_now;
	logic        value_wait;
	logic        take_value;
	logic        word_done;
	logic        addr_open;

	assign req        = hsel && hready && htrans[1];
	assign bad_size   = hsize != 3'b010; // R02
	assign ctl_write  = wr_pend_ff && addr_ff == `NRW_OFS_CONTROL;
	// Off bit as it stands once a write landing now is applied
	assign off_now    = ctl_write ? hwdata[`NRW_BIT_GEN_OFF] : gen_off_ff; // R04
	assign value_wait = rd_pend_ff && addr_ff == `NRW_OFS_VALUE;
	// Word handed over only while running
	assign take_value = value_wait && ready_ff && !gen_off_ff; // R05
	assign word_done  = !ready_ff && bits_ff == WORD_BITS && tick_ff == TICK_LAST;

	// Sampling: collect 16 noise bits, publish no faster than WORD_CYCLES
	always_comb begin
		nxt_gen_off = off_now; // R04
		nxt_shift   = shift_ff;
		nxt_value   = value_ff;
		nxt_ready   = ready_ff;
		nxt_tick    = tick_ff;
		nxt_bits    = bits_ff;
		if (off_now) begin
			// Stopped: a full collection restarts when switched back on
			nxt_ready = 1'b0; // R07
			nxt_tick  = '0;
			nxt_bits  = '0;
		end else begin
			if (tick_ff < TICK_LAST) begin
				nxt_tick = tick_ff + 7'd1; // R03
			end
			if (bits_ff < WORD_BITS) begin
				nxt_shift = {shift_ff[14:0], shift_ff[15] ^ noise_s2_ff};
				nxt_bits  = bits_ff + 5'd1;
			end
			// Set and clear cannot meet: one needs the flag low, the other high
			if (take_value) begin
				nxt_ready = 1'b0; // R10
			end else if (word_done) begin
				nxt_value = shift_ff;
				nxt_ready = 1'b1; // R06
				nxt_tick  = '0; // R03
				nxt_bits  = '0;
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			gen_off_ff <= 1'(`NRW_RST_CONTROL >> `NRW_BIT_GEN_OFF); // R09
			shift_ff   <= `NRW_RST_VALUE;
			value_ff   <= `NRW_RST_VALUE;
			ready_ff   <= 1'b0;
			tick_ff    <= '0;
			bits_ff    <= '0;
		end else begin
			gen_off_ff <= nxt_gen_off;
			shift_ff   <= nxt_shift;
			value_ff   <= nxt_value;
			ready_ff   <= nxt_ready;
			tick_ff    <= nxt_tick;
			bits_ff    <= nxt_bits;
		end
	end

	// Bus: address phase, data phase and the two-cycle error answer
	always_comb begin
		nxt_bus     = bus_ff;
		nxt_wr_pend = 1'b0;
		nxt_rd_pend = rd_pend_ff;
		nxt_addr    = addr_ff;
		nxt_rdata   = rdata_ff;
		addr_open   = 1'b0;
		case (bus_ff)
			NRW_IDLE: begin
				// Value read ends its data phase only after the word is loaded,
				// so hrdata already carries it when hreadyout rises
				if (value_wait) begin
					if (take_value) begin
						nxt_rdata   = {16'h0000, value_ff}; // R01
						nxt_rd_pend = 1'b0;
					end
				end else begin
					nxt_rd_pend = 1'b0;
					addr_open   = 1'b1;
				end
			end
			NRW_DATA: begin
				nxt_bus = NRW_ERR2;
			end
			NRW_ERR2: begin
				// Second error cycle has hready high, so a new address counts
				nxt_bus   = NRW_IDLE;
				addr_open = 1'b1;
			end
			default: begin
				nxt_bus = NRW_IDLE;
			end
		endcase
		if (addr_open && req) begin
			if (bad_size) begin
				nxt_bus = NRW_DATA; // R02
			end else begin
				nxt_addr = haddr;
				if (hwrite) begin
					nxt_wr_pend = 1'b1;
				end else begin
					nxt_rd_pend = 1'b1;
					// Off bit taken after any write landing now: no stale read-back
					case (haddr)
						`NRW_OFS_CONTROL: begin
							nxt_rdata = 32'(off_now) << `NRW_BIT_GEN_OFF; // R09
						end
						`NRW_OFS_STATUS: begin
							nxt_rdata = 32'(ready_ff && !off_now) << `NRW_BIT_READY; // R06 R07
						end
						default: begin
							nxt_rdata = 32'h0000_0000;
						end
					endcase
				end
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			bus_ff     <= NRW_IDLE;
			wr_pend_ff <= 1'b0;
			rd_pend_ff <= 1'b0;
			addr_ff    <= 8'h00;
			rdata_ff   <= 32'h0000_0000;
		end else begin
			bus_ff     <= nxt_bus;
			wr_pend_ff <= nxt_wr_pend;
			rd_pend_ff <= nxt_rd_pend;
			addr_ff    <= nxt_addr;
			rdata_ff   <= nxt_rdata;
		end
	end

	// Value read holds wait states until a word is ready
	always_comb begin
		hreadyout = 1'b1;
		hresp     = 1'b0;
		case (bus_ff)
			NRW_DATA: begin
				hreadyout = 1'b0;
				hresp     = 1'b1;
			end
			NRW_ERR2: begin
				hresp = 1'b1;
			end
			NRW_IDLE: begin
				hreadyout = !value_wait; // R05
			end
			default: begin
				hreadyout = 1'b1;
			end
		endcase
	end

	assign hrdata           = rdata_ff;
	assign osc_power_down   = gen_off_ff; // R04
	// Request only: the logic here keeps its clock, a gate outside acts on it
	assign gen_clk_gate_off = gen_off_ff; // R04

	// Two flops before any logic sees the noise pin
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			noise_s1_ff <= 1'b0;
			noise_s2_ff <= 1'b0;
		end else begin
			noise_s1_ff <= noise_bit;
			noise_s2_ff <= noise_s1_ff;
		end
	end
endmodule

// >>> rtl/nrw_cfg.svh
// Offsets, field positions, reset values and timing counts of the noise word source
`ifndef NRW_CFG_SVH
`define NRW_CFG_SVH
`define NRW_OFS_CONTROL   8'h00
`define NRW_OFS_STATUS    8'h04
`define NRW_OFS_VALUE     8'h08
`define NRW_BIT_GEN_OFF   2
`define NRW_BIT_READY     0
`define NRW_RST_CONTROL   32'h0000_0000
`define NRW_RST_VALUE     16'h0000
`define NRW_CLK_PERIOD_PS 25000
`define NRW_WORD_TIME_PS  1250000
`define NRW_WORD_CYCLES   ((`NRW_WORD_TIME_PS + `NRW_CLK_PERIOD_PS - 1) / `NRW_CLK_PERIOD_PS)
`endif

// >>> rtl/nrw_pkg.sv
// Types shared by the noise word source
package nrw_pkg;
	typedef enum logic [2:0] {
		NRW_IDLE  = 3'b001,
		NRW_DATA  = 3'b010,
		NRW_ERR2  = 3'b100
	} nrw_bus_type;
endpackage

// >>> verification/nrw_props_properties.sv
// Port checks for the noise word source
`timescale 1ns/1ps
module nrw_props (
	input wire logic        core_clk,
	input wire logic        sys_rst,
	input wire logic        hsel,
	input wire logic [7:0]  haddr,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic [2:0]  hsize,
	input wire logic [31:0] hrdata,
	input wire logic        hreadyout,
	input wire logic        hresp,
	input wire logic        osc_power_down,
	input wire logic        gen_clk_gate_off
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (sys_rst);
	// Bench ties hready to hreadyout, so it is left out here
	wire t = hsel & htrans[1] & hreadyout & hsize == 3'h2;
	wire b = hsel & htrans[1] & hreadyout & hsize != 3'h2;
	wire v = haddr == 8'h08;
	sequence err_pair; !hreadyout & hresp ##1 hreadyout & hresp; endsequence
	gate_same_a: assert property (osc_power_down == gen_clk_gate_off) else $error("gate");
	high_zero_a: assert property (hrdata[31:16] == 16'h0) else $error("high bits");
	err_pair_a: assert property (b |=> err_pair) else $error("no error");
	err_cause_a: assert property ($rose(hresp) |-> $past(b)) else $error("stray");
	fast_ok_a: assert property (t & !v |=> hreadyout & !hresp) else $error("slow");
	off_stall_a: assert property (t & v & !hwrite & osc_power_down |=> !hreadyout [*8])
		else $error("run");
	val_wait_a: assert property (t & v & !osc_power_down |=> ##[0:200] hreadyout) else $error("hang");
	val_ok_a: assert property (t & v |=> !hresp) else $error("val err");
endmodule
bind nrw_noise_word_source nrw_props i_props (.core_clk, .sys_rst, .hsel, .haddr, .htrans, .hwrite,
	.hsize, .hrdata, .hreadyout, .hresp, .osc_power_down, .gen_clk_gate_off);

// >>> verification/nrw_noise_model.sv
// Noise source model giving a changing bit every cycle
`timescale 1ns/1ps
module nrw_noise_model (
	input  wire logic core_clk,
	output logic      noise_bit
);
	logic [31:0] sh = 32'h32e765c0;
	// Free running: an analog source never idles
	always @(posedge core_clk) sh <= #1 {sh[30:0], sh[31] ^ sh[21] ^ sh[1] ^ sh[0]};
	assign noise_bit = sh[0];
endmodule

// >>> verification/tb_noise_random_word_source.sv
// Self-checking bench for the noise word source
`timescale 1ns/1ps
module tb_noise_random_word_source;
	logic        core_clk = 1'b0, sys_rst = 1'b1, hsel = 1'b0, hwrite = 1'b0, e;
	logic [7:0]  haddr = 8'h00;
	logic [1:0]  htrans = 2'h0;
	logic [2:0]  hsize = 3'h2;
	logic [31:0] hwdata = 32'h0, hrdata, q, sd = 32'h32e765c0;
	logic        hreadyout, hresp, noise_bit, osc_power_down, gen_clk_gate_off;
	int          num_errors = 0, tests_run = 0, ctl_m = 0;
	logic [15:0] seen[$];
	initial forever #12.5 core_clk = ~core_clk;
	nrw_noise_word_source i_dut (.core_clk, .sys_rst, .hsel, .haddr, .htrans, .hwrite, .hsize,
		.hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .noise_bit,
		.osc_power_down, .gen_clk_gate_off);
	nrw_noise_model i_noise (.core_clk, .noise_bit);
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic chk(input string n, input logic [31:0] got, exp);
		tests_run++;
		if (got !== exp) begin
			$display("MISMATCH %s exp %h got %h", n, exp, got);
			num_errors++;
		end
	endtask
	task automatic final_report;
		$display("checks %0d mismatches %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	task automatic xf(input logic w, input logic [7:0] a, input logic [31:0] d = 0,
		input logic [2:0] s = 3'h2);
		int n;
		{hsel, htrans, haddr, hwrite, hsize} = {1'b1, 2'h2, a, w, s};
		@(posedge core_clk) #1 {hsel, htrans, hwdata} = {3'h0, d};
		for (n = 0; n < 300 && hreadyout !== 1'b1; n++) @(posedge core_clk) #1;
		if (n == 300) begin
			num_errors++;
			final_report();
		end
		{q, e} = {hrdata, hresp};
		// Let the data phase end before the next call
		@(posedge core_clk) #1;
	endtask
	task automatic val_rd;
		xf(0, 8'h08);
		chk("hi", 32'(q[31:16]), 32'h0);
		chk("ve", 32'(e), 32'h0);
		foreach (seen[k]) chk("repeat", 32'(seen[k] == q[15:0]), 32'h0);
		seen.push_back(q[15:0]);
	endtask
	initial begin
		repeat (8) @(posedge core_clk);
		#1 sys_rst = 1'b0;
		xf(0, 8'h00); chk("ctl", q, 32'h0);
		xf(0, 8'h04); chk("sts", q, 32'h0);
		for (int i = 0; i < 4; i++) begin
			sd = lfsr(sd);
			// Off bit set in the refused control write, so a leak would show
			xf(1, 8'(i * 4), (i == 0) ? 32'h4 : sd, 3'(i & 1)); chk("err", 32'(e), 32'h1);
		end
		xf(1, 8'h04, sd); xf(0, 8'h0c); chk("unmap", q, 32'h0);
		xf(0, 8'h00); chk("ctl", q, 32'(ctl_m));
		$display("test refuse done");
		val_rd();
		xf(0, 8'h04); chk("clr", q, 32'h0);
		repeat (120) @(posedge core_clk);
		xf(0, 8'h04); chk("set", q, 32'h1);
		val_rd();
		// Waiting word outlived the word period, so the next one is due at once
		xf(0, 8'h04); chk("next", q, 32'h1);
		ctl_m = 4;
		xf(1, 8'h00, 32'(ctl_m)); xf(0, 8'h00); chk("rw", q, 32'(ctl_m));
		chk("pd", 32'(osc_power_down), 32'h1);
		chk("gate", 32'(gen_clk_gate_off), 32'h1);
		repeat (120) @(posedge core_clk);
		xf(0, 8'h04); chk("off", q, 32'h0);
		{hsel, htrans, haddr, hwrite} = {1'b1, 2'h2, 8'h08, 1'b0};
		@(posedge core_clk) #1 {hsel, htrans} = 3'h0;
		repeat (10) @(posedge core_clk);
		#1 chk("stall", 32'(hreadyout), 32'h0);
		sys_rst = 1'b1;
		repeat (2) @(posedge core_clk);
		#1 sys_rst = 1'b0;
		ctl_m = 0;
		xf(0, 8'h00); chk("ctl", q, 32'(ctl_m)); chk("pd", 32'(osc_power_down), 32'h0);
		chk("gate", 32'(gen_clk_gate_off), 32'h0);
		$display("test value done");
		final_report();
	end
endmodule
